// >>> shared/cpu_timer_clock_control_map.svh
`ifndef CPU_TIMER_CLOCK_CONTROL_MAP_SVH
`define CPU_TIMER_CLOCK_CONTROL_MAP_SVH

// Register offsets (byte addresses on the plain register port)
`define CTC_ADDR_W              9
`define CTC_OFS_CPU_USB_CLOCK   9'h030
`define CTC_OFS_TIMER_CLOCK     9'h031
`define CTC_OFS_USB_OSC_LOCK    9'h039
`define CTC_OFS_LOCK_STATUS     9'h03A
`define CTC_OFS_OSC_CONTROL0    9'h1E0

// Reset values
`define CTC_RST_CPU_USB_CLOCK   8'h00
`define CTC_RST_TIMER_CLOCK     8'h8F
`define CTC_RST_USB_OSC_LOCK    8'h00
`define CTC_RST_OSC_CONTROL0    8'h00

// Writable bit masks
`define CTC_WMASK_CPU_USB_CLOCK 8'h21
`define CTC_WMASK_TIMER_CLOCK   8'hFF
`define CTC_WMASK_USB_OSC_LOCK  8'h03
`define CTC_WMASK_OSC_CONTROL0  8'h3F

// Field positions
`define CTC_CPU_SEL_BIT         0
`define CTC_USB_SEL_BIT         5
`define CTC_NO_BUZZ_BIT         5
`define CTC_SLEEP_LO            3
`define CTC_CPU_SPEED_LO        0
`define CTC_LOCK_DIS_BIT        0
`define CTC_COARSE_INH_BIT      1
`define CTC_TCAP_DIV_LO         6
`define CTC_TCAP_SEL_LO         4
`define CTC_ITMR_DIV_LO         2
`define CTC_ITMR_SEL_LO         0

// Oscillator lock counts (24 MHz edges per 1 ms USB frame)
`define CTC_LOCK_EXPECT         16'h5DC0
`define CTC_LOCK_FINE_TOL       16'h005A
`define CTC_LOCK_COARSE_BAND    16'h0168
`define CTC_COARSE_TRIM_RST     5'h10
`define CTC_FINE_TRIM_RST       3'h4

// Watchdog period in sleep periods, minus one
`define CTC_WDT_LAST_PERIOD     2'h2

`endif

// >>> shared/cpu_timer_clock_control_pkg.sv
package cpu_timer_clock_control_pkg;

	// Oscillator lock sequencer
	typedef enum {
		LOCK_IDLE,
		LOCK_MEASURE,
		LOCK_ADJUST
	} lock_state_t;

	// Clock source field codes
	typedef enum logic [1:0] {
		SRC_OSC24,
		SRC_EXT,
		SRC_LP32K,
		SRC_CHAIN
	} clk_src_t;

endpackage : cpu_timer_clock_control_pkg

// >>> shared/clk_div_if.sv
interface clk_div_if #(parameter int RATIO_W = 8);
	logic               src_tick;
	logic [RATIO_W-1:0] ratio;
	logic               tick;

	modport div  (input src_tick, input ratio, output tick);
	modport user (output src_tick, output ratio, input tick);
endinterface : clk_div_if

// >>> design/clock_divide_enable.sv
// Turns source ticks into one enable pulse every ratio ticks
module clock_divide_enable #(
	parameter int RATIO_W = 8
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	clk_div_if.div    port_if
);
	logic [RATIO_W-1:0] count_reg;

	// Count source ticks; ratio of zero behaves as one
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_reg    <= '0;
			port_if.tick <= 1'b0;
		end else if (port_if.src_tick) begin
			if (count_reg + RATIO_W'(1) >= port_if.ratio) begin
				count_reg    <= '0;
				port_if.tick <= 1'b1;
			end else begin
				count_reg    <= count_reg + RATIO_W'(1);
				port_if.tick <= 1'b0;
			end
		end else begin
			port_if.tick <= 1'b0;
		end
	end

endmodule : clock_divide_enable

// >>> design/cpu_timer_clock_control.sv
// Function
// - Sleep monitor: duty-cycled, or always on
// - Monitor duty independent of sleep interval
// - Sleep field picks sleep and watchdog period
// - CPU divider resets to zero, divide eight
// - Internal source divider codes, 111 reserved
// - External source divides 8,4,2,1,16,32,128
// - Lock retrims oscillator only on internal USB
// - Lock disable bit stops packet trimming
// - Coarse inhibit leaves only fine tuning
// - USB engine source select bit
//
// The address-and-strobe port was left to the implementer.
`include "cpu_timer_clock_control_map.svh"

module cpu_timer_clock_control
	import cpu_timer_clock_control_pkg::*;
(
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	input  wire logic [`CTC_ADDR_W-1:0]   addr_i,
	input  wire logic [7:0]               wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [7:0]               rdata_o,
	input  wire logic                     osc_24m_i,
	input  wire logic                     lp_osc_32k_i,
	input  wire logic                     ext_clock_in_i,
	input  wire logic                     sleep_i,
	input  wire logic [1:0]               sleep_duty_trim_i,
	input  wire logic                     watchdog_clear_i,
	input  wire logic                     usb_frame_i,
	output logic                          cpu_clk_en_o,
	output logic                          capture_timer_clock_en_o,
	output logic                          interval_timer_clock_en_o,
	output logic                          sleep_tick_o,
	output logic                          watchdog_reset_o,
	output logic                          low_voltage_detect_en_o,
	output logic                          usb_serial_engine_ext_o,
	output logic      [4:0]               osc_coarse_trim_o,
	output logic      [2:0]               osc_fine_trim_o
);

	// Divide ratio for the CPU speed code; both sources share one table
	function automatic logic [7:0] cpu_ratio(input logic [2:0] code);
		case (code)
			3'h0:    cpu_ratio = 8'h08;
			3'h1:    cpu_ratio = 8'h04;
			3'h2:    cpu_ratio = 8'h02;
			3'h3:    cpu_ratio = 8'h01;
			3'h4:    cpu_ratio = 8'h10;
			3'h5:    cpu_ratio = 8'h20;
			3'h6:    cpu_ratio = 8'h80;
			default: cpu_ratio = 8'h08; // Reserved code falls back to default speed
		endcase
	endfunction : cpu_ratio

	// Timer divider code to ratio
	function automatic logic [7:0] timer_ratio(input logic [1:0] code);
		timer_ratio = 8'h01 << code;
	endfunction : timer_ratio

	// Sleep timer clock as 32 kHz ticks per period, minus one
	function automatic logic [14:0] sleep_last(input logic [1:0] code);
		case (code)
			2'h0:    sleep_last = 15'h003F;
			2'h1:    sleep_last = 15'h01FF;
			2'h2:    sleep_last = 15'h0FFF;
			default: sleep_last = 15'h7FFF;
		endcase
	endfunction : sleep_last

	// Monitor duty period in 32 kHz ticks, minus one
	function automatic logic [7:0] duty_last(input logic [1:0] code);
		duty_last = 8'(({8'h00, 8'h10} << code) - 16'h0001);
	endfunction : duty_last

	// Magnitude of a lock count error
	function automatic logic [15:0] abs_err(input logic [15:0] meas);
		abs_err = (meas > `CTC_LOCK_EXPECT) ? meas - `CTC_LOCK_EXPECT
		                                    : `CTC_LOCK_EXPECT - meas;
	endfunction : abs_err

	logic [7:0]  cpu_usb_clock_reg;
	logic [7:0]  timer_clock_reg;
	logic [7:0]  usb_osc_lock_reg;
	logic [7:0]  osc_control0_reg;
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic [2:0]  sync3_reg;
	logic        osc_tick;
	logic        lp_tick;
	logic        ext_tick;
	logic [14:0] sleep_cnt_reg;
	logic [1:0]  wdt_cnt_reg;
	logic [7:0]  duty_cnt_reg;
	lock_state_t lock_state_reg;
	logic [15:0] lock_cnt_reg;
	logic [15:0] lock_meas_reg;
	logic        lock_active;
	logic        cpu_from_ext;
	clk_src_t    tcap_src;
	clk_src_t    itmr_src;

	clk_div_if #(.RATIO_W(8)) cpu_div_if ();
	clk_div_if #(.RATIO_W(8)) tcap_div_if ();
	clk_div_if #(.RATIO_W(8)) itmr_div_if ();

	// Register writes; unmapped writes are dropped
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cpu_usb_clock_reg <= `CTC_RST_CPU_USB_CLOCK;
			timer_clock_reg   <= `CTC_RST_TIMER_CLOCK;
			usb_osc_lock_reg  <= `CTC_RST_USB_OSC_LOCK;
			osc_control0_reg  <= `CTC_RST_OSC_CONTROL0;
		end else if (wr_i) begin
			if (addr_i == `CTC_OFS_CPU_USB_CLOCK) begin
				cpu_usb_clock_reg <= wdata_i & `CTC_WMASK_CPU_USB_CLOCK;
			end else if (addr_i == `CTC_OFS_TIMER_CLOCK) begin
				timer_clock_reg <= wdata_i & `CTC_WMASK_TIMER_CLOCK;
			end else if (addr_i == `CTC_OFS_USB_OSC_LOCK) begin
				usb_osc_lock_reg <= wdata_i & `CTC_WMASK_USB_OSC_LOCK;
			end else if (addr_i == `CTC_OFS_OSC_CONTROL0) begin
				osc_control0_reg <= wdata_i & `CTC_WMASK_OSC_CONTROL0;
			end
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == `CTC_OFS_CPU_USB_CLOCK) begin
				rdata_o <= cpu_usb_clock_reg;
			end else if (addr_i == `CTC_OFS_TIMER_CLOCK) begin
				rdata_o <= timer_clock_reg;
			end else if (addr_i == `CTC_OFS_USB_OSC_LOCK) begin
				rdata_o <= usb_osc_lock_reg;
			end else if (addr_i == `CTC_OFS_OSC_CONTROL0) begin
				rdata_o <= osc_control0_reg;
			end else if (addr_i == `CTC_OFS_LOCK_STATUS) begin
				rdata_o <= {osc_coarse_trim_o, osc_fine_trim_o};
			end else begin
				rdata_o <= 8'h00;
			end
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Raw clocks enter through two flops; third flop only for edges
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			sync3_reg <= 3'h0;
		end else begin
			sync1_reg <= {ext_clock_in_i, lp_osc_32k_i, osc_24m_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Rising edges of each source; 24 MHz stays under half the core rate
	assign osc_tick = sync2_reg[0] & ~sync3_reg[0];
	assign lp_tick  = sync2_reg[1] & ~sync3_reg[1];
	assign ext_tick = sync2_reg[2] & ~sync3_reg[2];

	// Sleep forces the CPU back onto the internal oscillator
	assign cpu_from_ext = cpu_usb_clock_reg[`CTC_CPU_SEL_BIT] & ~sleep_i;

	// CPU clock divider feed; one table serves both sources
	assign cpu_div_if.src_tick = cpu_from_ext ? ext_tick : osc_tick;
	assign cpu_div_if.ratio    = cpu_ratio(osc_control0_reg[`CTC_CPU_SPEED_LO +: 3]);

	// Timer source selection ahead of each divider
	assign tcap_src = clk_src_t'(timer_clock_reg[`CTC_TCAP_SEL_LO +: 2]);
	assign itmr_src = clk_src_t'(timer_clock_reg[`CTC_ITMR_SEL_LO +: 2]);

	// Capture source; the spare code gives no clock
	always_comb begin
		case (tcap_src)
			SRC_OSC24: tcap_div_if.src_tick = osc_tick;
			SRC_EXT:   tcap_div_if.src_tick = ext_tick;
			SRC_LP32K: tcap_div_if.src_tick = lp_tick;
			default:   tcap_div_if.src_tick = 1'b0;
		endcase
	end

	// Interval source; last code chains the divided capture clock
	always_comb begin
		case (itmr_src)
			SRC_OSC24: itmr_div_if.src_tick = osc_tick;
			SRC_EXT:   itmr_div_if.src_tick = ext_tick;
			SRC_LP32K: itmr_div_if.src_tick = lp_tick;
			default:   itmr_div_if.src_tick = tcap_div_if.tick;
		endcase
	end

	assign tcap_div_if.ratio = timer_ratio(timer_clock_reg[`CTC_TCAP_DIV_LO +: 2]);
	assign itmr_div_if.ratio = timer_ratio(timer_clock_reg[`CTC_ITMR_DIV_LO +: 2]);

	clock_divide_enable #(.RATIO_W(8)) cpu_div_u (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.port_if    (cpu_div_if)
	);

	clock_divide_enable #(.RATIO_W(8)) tcap_div_u (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.port_if    (tcap_div_if)
	);

	clock_divide_enable #(.RATIO_W(8)) itmr_div_u (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.port_if    (itmr_div_if)
	);

	// Clock enables registered once more so outputs sit on flops
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cpu_clk_en_o              <= 1'b0;
			capture_timer_clock_en_o  <= 1'b0;
			interval_timer_clock_en_o <= 1'b0;
			usb_serial_engine_ext_o   <= 1'b0;
		end else begin
			cpu_clk_en_o              <= cpu_div_if.tick;
			capture_timer_clock_en_o  <= tcap_div_if.tick;
			interval_timer_clock_en_o <= itmr_div_if.tick;
			usb_serial_engine_ext_o   <= cpu_usb_clock_reg[`CTC_USB_SEL_BIT];
		end
	end

	// Sleep timer on the 32 kHz oscillator, one pulse per period
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sleep_cnt_reg <= 15'h0000;
			sleep_tick_o  <= 1'b0;
		end else if (lp_tick) begin
			if (sleep_cnt_reg >= sleep_last(osc_control0_reg[`CTC_SLEEP_LO +: 2])) begin
				sleep_cnt_reg <= 15'h0000;
				sleep_tick_o  <= 1'b1;
			end else begin
				sleep_cnt_reg <= sleep_cnt_reg + 15'h0001;
				sleep_tick_o  <= 1'b0;
			end
		end else begin
			sleep_tick_o <= 1'b0;
		end
	end

	// Watchdog fires after three unserviced sleep periods
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wdt_cnt_reg      <= 2'h0;
			watchdog_reset_o <= 1'b0;
		end else if (watchdog_clear_i) begin
			wdt_cnt_reg      <= 2'h0;
			watchdog_reset_o <= 1'b0;
		end else if (sleep_tick_o) begin
			if (wdt_cnt_reg == `CTC_WDT_LAST_PERIOD) begin
				wdt_cnt_reg      <= 2'h0;
				watchdog_reset_o <= 1'b1;
			end else begin
				wdt_cnt_reg      <= wdt_cnt_reg + 2'h1;
				watchdog_reset_o <= 1'b0;
			end
		end else begin
			watchdog_reset_o <= 1'b0;
		end
	end

	// Duty counter has its own count, untouched by the sleep interval
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			duty_cnt_reg <= 8'h00;
		end else if (lp_tick) begin
			if (duty_cnt_reg >= duty_last(sleep_duty_trim_i)) begin
				duty_cnt_reg <= 8'h00;
			end else begin
				duty_cnt_reg <= duty_cnt_reg + 8'h01;
			end
		end
	end

	// Supply monitor: always on when awake or forced, else one tick per period
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			low_voltage_detect_en_o <= 1'b1;
		end else begin
			low_voltage_detect_en_o <= ~sleep_i
				| osc_control0_reg[`CTC_NO_BUZZ_BIT]
				| (duty_cnt_reg == 8'h00);
		end
	end

	// Lock runs only on internal USB source with lock enabled
	assign lock_active = ~usb_osc_lock_reg[`CTC_LOCK_DIS_BIT]
	                   & ~cpu_usb_clock_reg[`CTC_USB_SEL_BIT];

	// Lock sequencer: count oscillator edges between USB frames
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			lock_state_reg <= LOCK_IDLE;
			lock_cnt_reg   <= 16'h0000;
			lock_meas_reg  <= 16'h0000;
		end else if (!lock_active) begin
			lock_state_reg <= LOCK_IDLE;
			lock_cnt_reg   <= 16'h0000;
		end else begin
			case (lock_state_reg)
				LOCK_IDLE: begin
					if (usb_frame_i) begin
						lock_state_reg <= LOCK_MEASURE;
						lock_cnt_reg   <= 16'h0000;
					end
				end
				LOCK_MEASURE: begin
					if (usb_frame_i) begin
						lock_meas_reg  <= lock_cnt_reg + {15'h0000, osc_tick};
						lock_cnt_reg   <= 16'h0000;
						lock_state_reg <= LOCK_ADJUST;
					end else if (lock_cnt_reg == 16'hFFFF) begin
						lock_state_reg <= LOCK_IDLE; // Traffic stopped
					end else begin
						lock_cnt_reg <= lock_cnt_reg + {15'h0000, osc_tick};
					end
				end
				default: begin
					lock_cnt_reg   <= lock_cnt_reg + {15'h0000, osc_tick};
					lock_state_reg <= LOCK_MEASURE;
				end
			endcase
		end
	end

	// Trim update; coarse step resets fine trim to centre
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			osc_coarse_trim_o <= `CTC_COARSE_TRIM_RST;
			osc_fine_trim_o   <= `CTC_FINE_TRIM_RST;
		end else if (lock_active && lock_state_reg == LOCK_ADJUST) begin
			if (abs_err(lock_meas_reg) > `CTC_LOCK_COARSE_BAND
			    && !usb_osc_lock_reg[`CTC_COARSE_INH_BIT]) begin
				if (lock_meas_reg < `CTC_LOCK_EXPECT && osc_coarse_trim_o != 5'h1F) begin
					osc_coarse_trim_o <= osc_coarse_trim_o + 5'h01;
				end else if (lock_meas_reg > `CTC_LOCK_EXPECT && osc_coarse_trim_o != 5'h00) begin
					osc_coarse_trim_o <= osc_coarse_trim_o - 5'h01;
				end
				osc_fine_trim_o <= `CTC_FINE_TRIM_RST;
			end else if (abs_err(lock_meas_reg) > `CTC_LOCK_FINE_TOL) begin
				// Fine steps saturate; limits the reach while coarse is inhibited
				if (lock_meas_reg < `CTC_LOCK_EXPECT && osc_fine_trim_o != 3'h7) begin
					osc_fine_trim_o <= osc_fine_trim_o + 3'h1;
				end else if (lock_meas_reg > `CTC_LOCK_EXPECT && osc_fine_trim_o != 3'h0) begin
					osc_fine_trim_o <= osc_fine_trim_o - 3'h1;
				end
			end
		end
	end

endmodule : cpu_timer_clock_control

// >>> dv/cpu_timer_clock_control_monitor.sv
`include "cpu_timer_clock_control_map.svh"

module cpu_timer_clock_control_monitor (
	input wire logic                   core_clk_i,
	input wire logic                   reset_i,
	input wire logic [`CTC_ADDR_W-1:0] addr_i,
	input wire logic [7:0]             wdata_i,
	input wire logic                   wr_i,
	input wire logic                   rd_i,
	input wire logic [7:0]             rdata_o,
	input wire logic                   sleep_i,
	input wire logic                   cpu_clk_en_o,
	input wire logic                   capture_timer_clock_en_o,
	input wire logic                   interval_timer_clock_en_o,
	input wire logic                   sleep_tick_o,
	input wire logic                   watchdog_reset_o,
	input wire logic                   low_voltage_detect_en_o,
	input wire logic                   usb_serial_engine_ext_o,
	input wire logic [4:0]             osc_coarse_trim_o,
	input wire logic [2:0]             osc_fine_trim_o
);
	logic [7:0] cpu_reg, tmr_reg, lock_reg, osc_reg;
	logic [9:0] tmr_age_reg;
	logic       lock_off;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	// Shadow copies of the writable registers, masked like the design
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cpu_reg  <= `CTC_RST_CPU_USB_CLOCK;
			tmr_reg  <= `CTC_RST_TIMER_CLOCK;
			lock_reg <= `CTC_RST_USB_OSC_LOCK;
			osc_reg  <= `CTC_RST_OSC_CONTROL0;
		end else if (wr_i) begin
			if (addr_i == `CTC_OFS_CPU_USB_CLOCK) cpu_reg <= wdata_i & `CTC_WMASK_CPU_USB_CLOCK;
			if (addr_i == `CTC_OFS_TIMER_CLOCK) tmr_reg <= wdata_i;
			if (addr_i == `CTC_OFS_USB_OSC_LOCK) lock_reg <= wdata_i & `CTC_WMASK_USB_OSC_LOCK;
			if (addr_i == `CTC_OFS_OSC_CONTROL0) osc_reg <= wdata_i & `CTC_WMASK_OSC_CONTROL0;
		end
	end

	// Age of timer setup; dividers may hold a residue for many ticks
	always_ff @(posedge core_clk_i) begin
		if (reset_i || (wr_i && addr_i == `CTC_OFS_TIMER_CLOCK)) tmr_age_reg <= 10'h000;
		else if (tmr_age_reg != 10'h3FF) tmr_age_reg <= tmr_age_reg + 10'h001;
	end

	// Lock must sit still when disabled or USB runs off the external clock
	assign lock_off = lock_reg[0] | cpu_reg[5];

	sequence s_lock_off;
		lock_off [*4];
	endsequence
	sequence s_chain;
		tmr_reg[3:0] == 4'h3 && tmr_age_reg == 10'h3FF && capture_timer_clock_en_o;
	endsequence

	property p_rd_idle;
		!$past(rd_i) |-> rdata_o == 8'h00;
	endproperty
	property p_rd_osc0;
		rd_i && addr_i == `CTC_OFS_OSC_CONTROL0 |=> rdata_o == $past(osc_reg);
	endproperty
	property p_cpu_pulse;
		cpu_clk_en_o |=> !cpu_clk_en_o;
	endproperty
	property p_wdt;
		watchdog_reset_o |-> $past(sleep_tick_o);
	endproperty
	property p_lvd;
		(!$past(sleep_i) && !$past(sleep_i, 2)) ||
		(osc_reg[5] && $past(osc_reg[5]) && $past(osc_reg[5], 2)) |-> low_voltage_detect_en_o;
	endproperty
	property p_lock_frozen;
		s_lock_off |-> $stable(osc_coarse_trim_o) && $stable(osc_fine_trim_o);
	endproperty
	property p_coarse_inh;
		lock_reg[1] [*4] |-> $stable(osc_coarse_trim_o);
	endproperty
	property p_usb_ext;
		$stable(cpu_reg[5]) [*2] |-> usb_serial_engine_ext_o == cpu_reg[5];
	endproperty
	property p_chain;
		s_chain |-> ##[0:2] interval_timer_clock_en_o;
	endproperty

	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read cycle");
	a_rd_osc0: assert property (p_rd_osc0)
		else $error("oscillator control readback wrong");
	a_cpu_pulse: assert property (p_cpu_pulse)
		else $error("cpu clock enable longer than one cycle");
	a_wdt: assert property (p_wdt)
		else $error("watchdog reset without a sleep tick before it");
	a_lvd: assert property (p_lvd)
		else $error("supply monitor off while awake or forced on");
	a_lock_frozen: assert property (p_lock_frozen)
		else $error("trim moved while lock inactive");
	a_coarse_inh: assert property (p_coarse_inh)
		else $error("coarse trim moved while inhibited");
	a_usb_ext: assert property (p_usb_ext)
		else $error("usb engine source differs from select bit");
	a_chain: assert property (p_chain)
		else $error("interval clock does not follow capture clock");
endmodule : cpu_timer_clock_control_monitor

bind cpu_timer_clock_control cpu_timer_clock_control_monitor cpu_timer_clock_control_monitor_i (
	.core_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i, .cpu_clk_en_o,
	.capture_timer_clock_en_o, .interval_timer_clock_en_o, .sleep_tick_o, .watchdog_reset_o,
	.low_voltage_detect_en_o, .usb_serial_engine_ext_o, .osc_coarse_trim_o, .osc_fine_trim_o
);

// >>> dv/cpu_timer_clock_control_test.sv
`include "cpu_timer_clock_control_map.svh"

module cpu_timer_clock_control_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic                   core_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
	logic                   sleep_i = 0, watchdog_clear_i = 0, usb_frame_i = 0;
	logic                   osc_24m_i = 0, lp_osc_32k_i = 0, ext_clock_in_i = 0;
	logic [`CTC_ADDR_W-1:0] addr_i = '0;
	logic [7:0]             wdata_i = '0, rdata_o;
	logic [1:0]             sleep_duty_trim_i = 2'h0;
	logic                   cpu_clk_en_o, capture_timer_clock_en_o, interval_timer_clock_en_o;
	logic                   sleep_tick_o, watchdog_reset_o, low_voltage_detect_en_o;
	logic                   usb_serial_engine_ext_o;
	logic [4:0]             osc_coarse_trim_o, coarse;
	logic [2:0]             osc_fine_trim_o, fine;
	logic [15:0]            gen_cnt = '0;
	int bad_count = 0, n_tests = 0, n_cpu, n_cap, n_itm, n_slp, n_wdt, n_low, i, x;
	int ratio[8] = '{8, 4, 2, 1, 16, 32, 128, 8};
	logic [8:0] ofs[4] = '{`CTC_OFS_CPU_USB_CLOCK, `CTC_OFS_TIMER_CLOCK,
		`CTC_OFS_USB_OSC_LOCK, `CTC_OFS_OSC_CONTROL0};
	logic [7:0] rst[4] = '{8'h00, 8'h8F, 8'h00, 8'h00};
	logic [7:0] msk[4] = '{8'h21, 8'hFF, 8'h03, 8'h3F};
	logic [7:0] tcfg[7] = '{8'h03, 8'h53, 8'hA3, 8'h33, 8'h34, 8'h35, 8'h3A};
	int tcap[7] = '{512, 128, 32, 0, 0, 0, 0};
	int titm[7] = '{512, 128, 32, 0, 256, 128, 32};

	cpu_timer_clock_control cpu_timer_clock_control_i (
		.core_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .osc_24m_i,
		.lp_osc_32k_i, .ext_clock_in_i, .sleep_i, .sleep_duty_trim_i, .watchdog_clear_i,
		.usb_frame_i, .cpu_clk_en_o, .capture_timer_clock_en_o, .interval_timer_clock_en_o,
		.sleep_tick_o, .watchdog_reset_o, .low_voltage_detect_en_o, .usb_serial_engine_ext_o,
		.osc_coarse_trim_o, .osc_fine_trim_o
	);

	always #5 core_clk_i = ~core_clk_i;

	// Source levels: 24M rises every 4 cycles, ext every 8, low-power every 16
	always @(posedge core_clk_i) begin
		gen_cnt <= gen_cnt + 16'h0001;
		osc_24m_i <= gen_cnt[1];
		ext_clock_in_i <= gen_cnt[2];
		lp_osc_32k_i <= gen_cnt[3];
	end

	task automatic chk(logic [7:0] got, logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Counts may drift by one from divider phase
	task automatic rng(logic [15:0] got, int lo, int hi);
		n_tests++;
		// Signed compare, so a low bound of minus one still admits zero
		if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask : rng

	task automatic wr(logic [8:0] a, logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(logic [8:0] a, logic [7:0] exp);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(rdata_o, exp);
	endtask : rd

	task automatic run(int n);
		{n_cpu, n_cap, n_itm, n_slp, n_wdt, n_low} = '0;
		repeat (n) begin
			@(negedge core_clk_i);
			n_cpu += cpu_clk_en_o;
			n_cap += capture_timer_clock_en_o;
			n_itm += interval_timer_clock_en_o;
			n_slp += sleep_tick_o;
			n_wdt += watchdog_reset_o;
			n_low += !low_voltage_detect_en_o;
		end
	endtask : run

	// One frame pulse every 1001 cycles: far fewer edges than the lock expects
	task automatic frames(int k);
		repeat (k) begin
			repeat (1000) @(posedge core_clk_i);
			usb_frame_i <= 1'b1;
			@(posedge core_clk_i);
			usb_frame_i <= 1'b0;
		end
		run(5);
	endtask : frames

	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Main sequence
	initial begin
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		run(1);
		chk({3'h0, osc_coarse_trim_o}, 8'h10);
		chk({5'h0, osc_fine_trim_o}, 8'h04);
		for (i = 0; i < 4; i++) begin
			rd(ofs[i], rst[i]);
			wr(ofs[i], 8'hFF);
			rd(ofs[i], msk[i]);
			wr(ofs[i], rst[i]);
		end
		wr(`CTC_OFS_LOCK_STATUS, 8'hFF);
		rd(`CTC_OFS_LOCK_STATUS, 8'h84);
		wr(9'h100, 8'hFF);
		rd(9'h100, 8'h00);
		// Every divider code, internal then external source; 111 acts as 000
		for (i = 0; i < 16; i++) begin
			wr(`CTC_OFS_CPU_USB_CLOCK, {7'h00, i[3]});
			wr(`CTC_OFS_OSC_CONTROL0, {5'h00, i[2:0]});
			run(200);
			run(2048);
			x = (i < 8 ? 512 : 256) / ratio[i % 8];
			rng(n_cpu, x - 1, x + 1);
		end
		wr(`CTC_OFS_CPU_USB_CLOCK, 8'h00);
		for (i = 0; i < 7; i++) begin
			wr(`CTC_OFS_TIMER_CLOCK, tcfg[i]);
			run(200);
			run(2048);
			rng(n_cap, tcap[i] - 1, tcap[i] + 1);
			rng(n_itm, titm[i] - 1, titm[i] + 1);
		end
		// Sleep period 64 ticks, watchdog after three
		wr(`CTC_OFS_OSC_CONTROL0, 8'h00);
		@(posedge core_clk_i) watchdog_clear_i <= 1'b1;
		@(posedge core_clk_i) watchdog_clear_i <= 1'b0;
		run(3100);
		rng(n_wdt, 1, 1);
		rng(n_slp, 3, 4);
		wr(`CTC_OFS_OSC_CONTROL0, 8'h08);
		run(16500);
		rng(n_slp, 1, 3);
		// Monitor duty in sleep, then forced on
		wr(`CTC_OFS_OSC_CONTROL0, 8'h00);
		@(posedge core_clk_i) sleep_i <= 1'b1;
		run(3000);
		rng(n_low, 2500, 2999);
		// Longer duty period with the longest sleep interval; duty must not follow it
		@(posedge core_clk_i) sleep_duty_trim_i <= 2'h1;
		wr(`CTC_OFS_OSC_CONTROL0, 8'h18);
		run(3000);
		rng(n_low, 2850, 2990);
		wr(`CTC_OFS_OSC_CONTROL0, 8'h20);
		run(3);
		run(2000);
		rng(n_low, 0, 0);
		@(posedge core_clk_i) sleep_i <= 1'b0;
		// Lock disabled, enabled, coarse inhibited, USB on external clock
		// CPU stays at divide eight while frames arrive
		wr(`CTC_OFS_USB_OSC_LOCK, 8'h01);
		frames(3);
		chk({3'h0, osc_coarse_trim_o}, 8'h10);
		chk({5'h0, osc_fine_trim_o}, 8'h04);
		wr(`CTC_OFS_USB_OSC_LOCK, 8'h00);
		frames(3);
		rng(osc_coarse_trim_o, 8'h11, 8'h12);
		coarse = osc_coarse_trim_o;
		wr(`CTC_OFS_USB_OSC_LOCK, 8'h02);
		frames(3);
		chk({3'h0, osc_coarse_trim_o}, {3'h0, coarse});
		rng(osc_fine_trim_o, 5, 7);
		wr(`CTC_OFS_USB_OSC_LOCK, 8'h00);
		wr(`CTC_OFS_CPU_USB_CLOCK, 8'h20);
		{coarse, fine} = {osc_coarse_trim_o, osc_fine_trim_o};
		frames(3);
		chk({3'h0, osc_coarse_trim_o}, {3'h0, coarse});
		chk({5'h0, osc_fine_trim_o}, {5'h0, fine});
		chk({7'h0, usb_serial_engine_ext_o}, 8'h01);
		stop_test();
	end
endmodule : cpu_timer_clock_control_test
